// ### rtl/sps_prio_map.v
`timescale 1ns/100ps
`include "sps_defines.vh"

// resolves one frame's class octet against the full code-point map
module sps_prio_map
(
  // clock and reset
  input wire clk,
  input wire reset,
  // frame side
  input wire frame_valid,
  input wire frame_is_ip,
  input wire [7:0] frame_class_octet,
  // map contents
  input wire [`SPS_MAP_BITS-1:0] map_bits,
  // result
  output reg prio_valid_q,
  output reg prio_hit_q,
  output reg [`SPS_PRIO_BITS-1:0] prio_q
);

  wire [`SPS_CODE_BITS-1:0] code;
  reg [`SPS_PRIO_BITS-1:0] field_d;
  integer i;

  // upper six bits of the octet select one of 64 fields
  assign code = frame_class_octet[7:2];

  always @*
  begin
    field_d = {`SPS_PRIO_BITS{1'b0}};
    for (i = 0; i < (1 << `SPS_CODE_BITS); i = i + 1)
    begin
      if (code == i[`SPS_CODE_BITS-1:0])
      begin
        field_d = map_bits[i*`SPS_PRIO_BITS +: `SPS_PRIO_BITS];
      end
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      prio_valid_q <= 1'b0;
      prio_hit_q <= 1'b0;
      prio_q <= {`SPS_PRIO_BITS{1'b0}};
    end
    else
    begin
      prio_valid_q <= frame_valid;
      if (frame_valid)
      begin
        // non-ip frames are left to the other classifiers
        prio_hit_q <= frame_is_ip;
        prio_q <= frame_is_ip ? field_d : {`SPS_PRIO_BITS{1'b0}};
      end
    end
  end

endmodule

// ### rtl/sps_regs.v
// Functional notes
// - status a bit 7 shows crossover wiring
// - status a bit 6 shows autonegotiation done
// - status a bit 5 shows link good
// - status a bit 4 shows partner pause ability
// - status a bits 3-0 show partner abilities
// - port 3 status a location is reserved
// - status b bit 7 selects crossover algorithm
// - status b bit 6 reserved, reads zero
// - status b bit 5 shows reversed polarity
// - status b bit 4 shows transmit flow control
// - status b bit 3 shows receive flow control
// - status b bits 2,1 show speed, duplex
// - status b bit 0 shows far-end fault
// - reset register: soft reset, coding sublayer reset
// - six code bits pick a 2-bit priority field
// - map 0 covers codes 0x00 to 0x0c
// - map 1 covers codes 0x10 to 0x1c
// - map 2 covers codes 0x20 to 0x2c
`timescale 1ns/100ps
`include "sps_defines.vh"

module sps_regs
(
  // clock and reset
  input wire clk,
  input wire reset,
  // register access port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  // phy port status, index 0 is port 1, index 1 is port 2
  input wire [1:0] crossover_state,
  input wire [1:0] autoneg_complete,
  input wire [1:0] link_good,
  input wire [1:0] partner_pause,
  input wire [1:0] partner_100_full,
  input wire [1:0] partner_100_half,
  input wire [1:0] partner_10_full,
  input wire [1:0] partner_10_half,
  input wire [1:0] polarity_reversed,
  input wire far_end_fault,
  // mac status, index 2 is port 3
  input wire [2:0] tx_flow_active,
  input wire [2:0] rx_flow_active,
  input wire [2:0] speed_100,
  input wire [2:0] full_duplex,
  // controls
  output reg [1:0] crossover_algorithm_select_q,
  output reg soft_reset_q,
  output reg coding_sublayer_reset_q,
  // frame classification
  input wire frame_valid,
  input wire frame_is_ip,
  input wire [7:0] frame_class_octet,
  input wire [`SPS_MAP_BITS-`SPS_LOW_MAP_BITS-1:0] upper_map,
  output wire prio_valid_q,
  output wire prio_hit_q,
  output wire [`SPS_PRIO_BITS-1:0] prio_q
);

  localparam NSTAT = 31;
  // ports 1 and 2 carry phys; port 3 is the mii port with mac status only
  localparam NPHY = 2;
  localparam NPORT = 3;
  // far-end fault is only detected on port 1
  localparam FEF_PORT = 0;

  // status arrives from phy and mac logic that may run on other clocks
  // bits cross one by one, so a read may catch a mix of old and new levels
  wire [NSTAT-1:0] stat_raw;
  reg [NSTAT-1:0] stat_meta_q;
  reg [NSTAT-1:0] stat_q;

  assign stat_raw = {crossover_state, autoneg_complete, link_good, partner_pause,
                     partner_100_full, partner_100_half, partner_10_full, partner_10_half,
                     polarity_reversed, far_end_fault,
                     tx_flow_active, rx_flow_active, speed_100, full_duplex};

  always @(posedge clk)
  begin
    if (reset)
    begin
      stat_meta_q <= {NSTAT{1'b0}};
      stat_q <= {NSTAT{1'b0}};
    end
    else
    begin
      stat_meta_q <= stat_raw;
      stat_q <= stat_meta_q;
    end
  end

  // unpack synchronised status
  wire [1:0] s_xover;
  wire [1:0] s_an;
  wire [1:0] s_link;
  wire [1:0] s_pause;
  wire [1:0] s_100f;
  wire [1:0] s_100h;
  wire [1:0] s_10f;
  wire [1:0] s_10h;
  wire [1:0] s_pol;
  wire s_fef;
  wire [2:0] s_txfc;
  wire [2:0] s_rxfc;
  wire [2:0] s_spd;
  wire [2:0] s_dup;

  assign {s_xover, s_an, s_link, s_pause, s_100f, s_100h, s_10f, s_10h,
          s_pol, s_fef, s_txfc, s_rxfc, s_spd, s_dup} = stat_q;

  // assemble per-port status images
  wire [7:0] stat_a [0:1];
  wire [7:0] stat_b [0:2];

  genvar p;
  generate
    for (p = 0; p < NPHY; p = p + 1)
    begin : g_phy
      assign stat_a[p] = {s_xover[p],
                          s_an[p],
                          s_link[p],
                          s_pause[p],
                          s_100f[p], s_100h[p], s_10f[p], s_10h[p]};
    end
    for (p = 0; p < NPORT; p = p + 1)
    begin : g_port
      wire xsel;
      wire pol;
      wire fef;
      // port 3 is the mii port: no crossover, polarity or far-end fault
      if (p < NPHY)
      begin : g_has_phy
        assign xsel = crossover_algorithm_select_q[p];
        assign pol = s_pol[p];
      end
      else
      begin : g_no_phy
        assign xsel = 1'b0;
        assign pol = 1'b0;
      end
      // far-end fault exists on port 1 only
      assign fef = (p == FEF_PORT) ? s_fef : 1'b0;
      assign stat_b[p] = {xsel,
                          1'b0,
                          pol,
                          s_txfc[p],
                          s_rxfc[p],
                          s_spd[p], s_dup[p],
                          fef};
    end
  endgenerate

  // software-held state
  reg [7:0] map0_q;
  reg [7:0] map1_q;
  reg [7:0] map2_q;

  // one write strobe per writable location; writes anywhere else are dropped
  wire wr_p1_b;
  wire wr_p2_b;
  wire wr_rst;
  wire wr_map0;
  wire wr_map1;
  wire wr_map2;

  assign wr_p1_b = reg_wr && (reg_addr == `SPS_P1_STAT_B);
  assign wr_p2_b = reg_wr && (reg_addr == `SPS_P2_STAT_B);
  assign wr_rst = reg_wr && (reg_addr == `SPS_RESET_CTL);
  assign wr_map0 = reg_wr && (reg_addr == `SPS_MAP_0);
  assign wr_map1 = reg_wr && (reg_addr == `SPS_MAP_1);
  assign wr_map2 = reg_wr && (reg_addr == `SPS_MAP_2);

  // only bit 7 of a phy status b location takes write data
  always @(posedge clk)
  begin
    if (reset)
    begin
      crossover_algorithm_select_q <= {2{`SPS_XOVER_SEL_RST}};
    end
    else
    begin
      if (wr_p1_b)
      begin
        crossover_algorithm_select_q[0] <= reg_wdata[`SPS_B_XOVER_SEL];
      end
      if (wr_p2_b)
      begin
        crossover_algorithm_select_q[1] <= reg_wdata[`SPS_B_XOVER_SEL];
      end
    end
  end

  // request levels stay as written; they never reset this block itself
  always @(posedge clk)
  begin
    if (reset)
    begin
      soft_reset_q <= 1'b0;
      coding_sublayer_reset_q <= 1'b0;
    end
    else if (wr_rst)
    begin
      // a written 0 withdraws the request
      soft_reset_q <= reg_wdata[`SPS_RST_SOFT];
      coding_sublayer_reset_q <= reg_wdata[`SPS_RST_PCS];
    end
  end

  // a frame taken in the cycle of a map write still sees the old map
  always @(posedge clk)
  begin
    if (reset)
    begin
      map0_q <= `SPS_MAP_RST;
      map1_q <= `SPS_MAP_RST;
      map2_q <= `SPS_MAP_RST;
    end
    else
    begin
      if (wr_map0)
      begin
        map0_q <= reg_wdata;
      end
      if (wr_map1)
      begin
        map1_q <= reg_wdata;
      end
      if (wr_map2)
      begin
        map2_q <= reg_wdata;
      end
    end
  end

  // read mux
  // a read in the cycle of a write returns the value from before it
  reg [7:0] rdata_d;

  always @*
  begin
    rdata_d = `SPS_ZERO8;
    case (reg_addr)
      `SPS_P1_STAT_A: rdata_d = stat_a[0];
      `SPS_P1_STAT_B: rdata_d = stat_b[0];
      `SPS_P2_STAT_A: rdata_d = stat_a[1];
      `SPS_P2_STAT_B: rdata_d = stat_b[1];
      `SPS_P3_STAT_A: rdata_d = `SPS_ZERO8;
      `SPS_P3_STAT_B: rdata_d = stat_b[2];
      `SPS_RESET_CTL:
      begin
        rdata_d[`SPS_RST_SOFT] = soft_reset_q;
        rdata_d[`SPS_RST_PCS] = coding_sublayer_reset_q;
      end
      `SPS_MAP_0: rdata_d = map0_q;
      `SPS_MAP_1: rdata_d = map1_q;
      `SPS_MAP_2: rdata_d = map2_q;
      default: rdata_d = `SPS_ZERO8;
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata_q <= `SPS_ZERO8;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      // read data holds until the next read
      if (reg_rd)
      begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  // low 24 bits of the map live here, the upper 104 bits come in on upper_map
  wire [`SPS_MAP_BITS-1:0] map_all;

  assign map_all = {upper_map, map2_q, map1_q, map0_q};

  sps_prio_map u_prio_map
  (
    .clk(clk),
    .reset(reset),
    .frame_valid(frame_valid),
    .frame_is_ip(frame_is_ip),
    .frame_class_octet(frame_class_octet),
    .map_bits(map_all),
    .prio_valid_q(prio_valid_q),
    .prio_hit_q(prio_hit_q),
    .prio_q(prio_q)
  );

endmodule

// ### shared/sps_defines.vh
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// register offsets
`define SPS_P1_STAT_A 8'h1e
`define SPS_P1_STAT_B 8'h1f
`define SPS_P2_STAT_A 8'h2e
`define SPS_P2_STAT_B 8'h2f
`define SPS_P3_STAT_A 8'h3e
`define SPS_P3_STAT_B 8'h3f
`define SPS_RESET_CTL 8'h43
`define SPS_MAP_0 8'h60
`define SPS_MAP_1 8'h61
`define SPS_MAP_2 8'h62

// status b field positions
`define SPS_B_XOVER_SEL 7
`define SPS_B_RSVD 6
`define SPS_B_POL_REV 5
`define SPS_B_TX_FC 4
`define SPS_B_RX_FC 3
`define SPS_B_SPEED 2
`define SPS_B_DUPLEX 1
`define SPS_B_FAR_FAULT 0

// reset control field positions
`define SPS_RST_SOFT 4
`define SPS_RST_PCS 0

// reset values
`define SPS_XOVER_SEL_RST 1'b1
`define SPS_MAP_RST 8'h00
`define SPS_ZERO8 8'h00

// priority map geometry
`define SPS_MAP_BITS 128
`define SPS_LOW_MAP_BITS 24
`define SPS_CODE_BITS 6
`define SPS_PRIO_BITS 2

`endif

// ### tb/sps_regs_chk.sv
`timescale 1ns/100ps
module sps_regs_chk
(
  // clock and reset
  input logic clk,
  input logic reset,
  // register port
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata_q,
  input logic reg_rvalid_q,
  // controls
  input logic [1:0] crossover_algorithm_select_q,
  input logic soft_reset_q,
  input logic coding_sublayer_reset_q,
  // classifier
  input logic frame_valid,
  input logic frame_is_ip,
  input logic prio_valid_q,
  input logic prio_hit_q,
  input logic [1:0] prio_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_read_answered: assert property (reg_rd |=> reg_rvalid_q) else $error("read not answered");
  a_no_stray_rvalid: assert property (!reg_rd |=> !reg_rvalid_q) else $error("stray read valid");
  a_rsvd_a_zero: assert property (reg_rd && reg_addr == 8'h3e |=> reg_rdata_q == 8'h00)
    else $error("reserved location not zero");
  a_rsvd_b_zero: assert property (reg_rd && reg_addr[3:0] == 4'hf && reg_addr[7:6] == 2'h0
    && reg_addr[5:4] != 2'h0 |=> !reg_rdata_q[6]) else $error("reserved bit set");
  a_xsel_write: assert property (reg_wr && reg_addr == 8'h2f
    |=> crossover_algorithm_select_q[1] == $past(reg_wdata[7])) else $error("select not written");
  a_rst_ctl_write: assert property (reg_wr && reg_addr == 8'h43
    |=> {soft_reset_q, coding_sublayer_reset_q} == {$past(reg_wdata[4]), $past(reg_wdata[0])})
    else $error("reset control not written");
  a_rst_ctl_hold: assert property (!(reg_wr && reg_addr == 8'h43)
    |=> $stable(soft_reset_q) && $stable(coding_sublayer_reset_q)) else $error("reset control moved");
  a_frame_answered: assert property (frame_valid |=> prio_valid_q) else $error("frame not answered");
  a_no_stray_prio: assert property (!frame_valid |=> !prio_valid_q) else $error("stray priority");
  a_ip_frame_hit: assert property (frame_valid && frame_is_ip |=> prio_hit_q) else $error("ip miss");
  a_nonip_no_hit: assert property (frame_valid && !frame_is_ip |=> !prio_hit_q && prio_q == 2'b00)
    else $error("non-ip frame classified");
endmodule
bind sps_regs sps_regs_chk chk(.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .crossover_algorithm_select_q(crossover_algorithm_select_q), .soft_reset_q(soft_reset_q),
  .coding_sublayer_reset_q(coding_sublayer_reset_q), .frame_valid(frame_valid),
  .frame_is_ip(frame_is_ip), .prio_valid_q(prio_valid_q), .prio_hit_q(prio_hit_q), .prio_q(prio_q));

// ### tb/sps_regs_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module sps_regs_tb;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, frame_valid = 0, frame_is_ip = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q, frame_class_octet = 0;
  logic reg_rvalid_q, soft_reset_q, coding_sublayer_reset_q, prio_valid_q, prio_hit_q;
  logic [1:0] crossover_algorithm_select_q, prio_q;
  logic [1:0][7:0] sa = 0;
  logic [2:0][7:0] sb = 0;
  logic [103:0] upper_map = {2'b01, 100'h0, 2'b11};
  logic [23:0] m = 24'h9c1be4;
  int mismatches = 0, comparisons = 0, cyc = 0;
  sps_regs uut(.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .crossover_state({sa[1][7], sa[0][7]}), .autoneg_complete({sa[1][6], sa[0][6]}),
    .link_good({sa[1][5], sa[0][5]}), .partner_pause({sa[1][4], sa[0][4]}),
    .partner_100_full({sa[1][3], sa[0][3]}), .partner_100_half({sa[1][2], sa[0][2]}),
    .partner_10_full({sa[1][1], sa[0][1]}), .partner_10_half({sa[1][0], sa[0][0]}),
    .polarity_reversed({sb[1][5], sb[0][5]}), .far_end_fault(sb[0][0]),
    .tx_flow_active({sb[2][4], sb[1][4], sb[0][4]}), .rx_flow_active({sb[2][3], sb[1][3], sb[0][3]}),
    .speed_100({sb[2][2], sb[1][2], sb[0][2]}), .full_duplex({sb[2][1], sb[1][1], sb[0][1]}),
    .crossover_algorithm_select_q(crossover_algorithm_select_q), .soft_reset_q(soft_reset_q),
    .coding_sublayer_reset_q(coding_sublayer_reset_q), .frame_valid(frame_valid),
    .frame_is_ip(frame_is_ip), .frame_class_octet(frame_class_octet), .upper_map(upper_map),
    .prio_valid_q(prio_valid_q), .prio_hit_q(prio_hit_q), .prio_q(prio_q));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      finish_test;
    end
  end
  task automatic wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    @(negedge clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 0;
    `CHK("rvalid", 1'b1, reg_rvalid_q)
    `CHK("rdata", e, reg_rdata_q)
  endtask
  // frame_valid stays up so successive calls run back to back
  task automatic frm(input [7:0] oct, input ip, input [1:0] e);
    @(negedge clk);
    frame_valid = 1;
    frame_is_ip = ip;
    frame_class_octet = oct;
    @(posedge clk);
    #1;
    `CHK("prio_valid", 1'b1, prio_valid_q)
    `CHK("prio_hit", ip, prio_hit_q)
    `CHK("prio", e, prio_q)
  endtask
  task automatic t_defaults;
    rd(8'h1f, 8'h80);
    rd(8'h3f, 8'h00);
    rd(8'h43, 8'h00);
    `CHK("xsel", 2'b11, crossover_algorithm_select_q)
    $display("defaults done");
  endtask
  task automatic t_status;
    sa = {8'h5a, 8'ha5};
    sb = {3{8'hff}};
    repeat (3) @(negedge clk);
    rd(8'h1e, 8'ha5);
    rd(8'h2e, 8'h5a);
    wr(8'h3e, 8'hff);
    rd(8'h3e, 8'h00);
    rd(8'h70, 8'h00);
    rd(8'h1f, 8'hbf);
    rd(8'h2f, 8'hbe);
    rd(8'h3f, 8'h1e);
    wr(8'h1f, 8'h00);
    `CHK("xsel", 2'b10, crossover_algorithm_select_q)
    // software clears the port 2 crossover select bit; the reserved bit goes in at its default
    wr(8'h2f, 8'h00);
    rd(8'h2f, 8'h3e);
    sb = {8'h00, 8'h00, 8'h15};
    repeat (3) @(negedge clk);
    rd(8'h1f, 8'h15);
    $display("status done");
  endtask
  task automatic t_reset_ctl;
    wr(8'h43, 8'h11);
    `CHK("soft", 1'b1, soft_reset_q)
    `CHK("pcs", 1'b1, coding_sublayer_reset_q)
    wr(8'h43, 8'h10);
    `CHK("pcs", 1'b0, coding_sublayer_reset_q)
    wr(8'h43, 8'h01);
    `CHK("soft", 1'b0, soft_reset_q)
    rd(8'h43, 8'h01);
    $display("reset control done");
  endtask
  task automatic t_map;
    wr(8'h60, m[7:0]);
    wr(8'h61, m[15:8]);
    wr(8'h62, m[23:16]);
    rd(8'h61, m[15:8]);
    for (int i = 0; i < 12; i++)
      frm(8'(i * 4 + i % 4), 1'b1, m[2 * i +: 2]);
    frm(8'h30, 1'b1, 2'b11);
    frm(8'hfc, 1'b1, 2'b01);
    frm(8'h04, 1'b0, 2'b00);
    @(negedge clk);
    frame_valid = 0;
    $display("priority map done");
  endtask
  task automatic t_mid_reset;
    @(negedge clk);
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    `CHK("xsel", 2'b11, crossover_algorithm_select_q)
    `CHK("pcs", 1'b0, coding_sublayer_reset_q)
    rd(8'h60, 8'h00);
    rd(8'h62, 8'h00);
    rd(8'h43, 8'h00);
    frm(8'h08, 1'b1, 2'b00);
    @(negedge clk);
    frame_valid = 0;
    $display("mid-run reset done");
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    reset = 0;
    t_defaults();
    t_status();
    t_reset_ctl();
    t_map();
    t_mid_reset();
    finish_test;
  end
endmodule
